// [hdl/fcr_regs.vh]
// register offsets, field positions, reset values and frame constants of the filter control bank
`ifndef FCR_REGS_VH
`define FCR_REGS_VH

// ----------------------------------------
// frame layout
// ----------------------------------------
`define FCR_FRAME_BITS      6'd32
`define FCR_DATA_W          24
`define FCR_ADDR_W          5
`define FCR_CHIP_ADDR       3'h5

// ----------------------------------------
// register offsets
// ----------------------------------------
`define FCR_ADDR_IDENT      5'h00
`define FCR_ADDR_ENABLE     5'h01
`define FCR_ADDR_SETTINGS   5'h02
`define FCR_ADDR_TUNE       5'h03

// ----------------------------------------
// field positions
// ----------------------------------------
`define FCR_RPTR_MSB        4
`define FCR_SOFT_RST_BIT    5
`define FCR_EN_NVM_IGN      0
`define FCR_EN_CAL          1
`define FCR_EN_I            2
`define FCR_EN_Q            3
`define FCR_EN_FORCE        4
`define FCR_EN_DOUBLER      5
`define FCR_EN_ZIN_LSB      9
`define FCR_ENABLE_MASK     24'h00023F
`define FCR_SETTINGS_MASK   24'h0007FF
`define FCR_TUNE_MASK       24'h00000F
`define FCR_SET_ZIN_MSB     10

// ----------------------------------------
// reset values
// ----------------------------------------
`define FCR_ENABLE_RST      24'h00000C
`define FCR_SETTINGS_RST    24'h000009
`define FCR_TUNE_RST        24'h000000
`define FCR_TUNE_MAX        4'hB
`define FCR_IDENT_DEFAULT   24'h123456

`endif

// [hdl/fcr_bank.v]
// serial register bank controlling a dual programmable low-pass filter
`timescale 1ns/1ps
`default_nettype none
`include "fcr_regs.vh"

module fcr_bank #(
	parameter [23:0] IDENT_VALUE = `FCR_IDENT_DEFAULT // arbitrary value
) (
	// clock and reset
	input  wire        core_clk_i,
	input  wire        rst_n_i,
	input  wire        clk_en_i,
	// serial port pins
	input  wire        sck_i,
	input  wire        sen_n_i,
	input  wire        sdi_i,
	output wire        sdo_o,
	output wire        sdo_oe_o,
	// configuration outputs
	output wire        nonvolatile_ignore_o,
	output wire        cal_enable_o,
	output wire        chan_i_enable_o,
	output wire        chan_q_enable_o,
	output wire        force_tune_o,
	output wire        doubler_enable_o,
	output wire [1:0]  amp_bias_o,
	output wire [1:0]  drv_bias_o,
	output wire        high_gain_select_o,
	output wire        bypass_o,
	output wire [3:0]  coarse_bw_o,
	output wire [1:0]  zin_select_o,
	output wire [3:0]  fine_tune_o,
	output wire        use_nonvolatile_o,
	output reg         soft_reset_o,
	// external status
	input  wire        nvm_programmed_i,
	input  wire [3:0]  cal_result_i
);

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	reg  [1:0] rst_sync_reg;
	wire       rst_n;

	// deassert synchronously so no flop leaves reset on a different edge
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	localparam PIN_SCK = 0;
	localparam PIN_SEN = 1;
	localparam PIN_SDI = 2;

	wire [2:0] pin_raw;
	wire [2:0] pin_settled;
	wire [2:0] pin_level;
	reg  [1:0] edge_state_reg;

	// a change is trusted once the second and third stage agree
	function fcr_agree;
		input [2:0] stages;
		begin
			fcr_agree = (stages[1] == stages[2]);
		end
	endfunction

	// pin order inside the chains: clock, enable, data
	assign pin_raw = {sdi_i, sen_n_i, sck_i};

	// one three-flop chain per pin; stage one feeds only stage two
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_sync
			// chains start at the idle level so reset cannot fake an edge
			localparam [2:0] IDLE = (g == PIN_SEN) ? 3'h7 : 3'h0;
			reg  [2:0] chain_reg;
			always @(posedge core_clk_i or negedge rst_n) begin
				if (!rst_n)
					chain_reg <= IDLE;
				else if (clk_en_i)
					chain_reg <= {chain_reg[1:0], pin_raw[g]};
			end
			assign pin_settled[g] = fcr_agree(chain_reg);
			assign pin_level[g]   = chain_reg[2];
		end
	endgenerate

	// last trusted level of the clock pin (bit 0) and the enable pin (bit 1)
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			edge_state_reg <= 2'h2; // clock idle low, enable idle high
		end else if (clk_en_i) begin
			if (pin_settled[PIN_SCK])
				edge_state_reg[0] <= pin_level[PIN_SCK];
			if (pin_settled[PIN_SEN])
				edge_state_reg[1] <= pin_level[PIN_SEN];
		end
	end

	// edges are taken against the last trusted level, so a glitch that
	// never reaches both late stages is not counted
	wire sck_rise = pin_settled[PIN_SCK] & pin_level[PIN_SCK] & ~edge_state_reg[0];
	wire sck_fall = pin_settled[PIN_SCK] & ~pin_level[PIN_SCK] & edge_state_reg[0];
	wire sen_rise = pin_settled[PIN_SEN] & pin_level[PIN_SEN] & ~edge_state_reg[1];
	wire sen_fall = pin_settled[PIN_SEN] & ~pin_level[PIN_SEN] & edge_state_reg[1];
	wire active   = ~edge_state_reg[1];
	wire sdi_bit  = pin_level[PIN_SDI];

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	reg  [23:0] enable_reg;
	reg  [23:0] settings_reg;
	reg  [23:0] tune_reg;
	reg  [4:0]  rptr_reg;
	reg  [31:0] shift_in_reg;
	reg  [31:0] shift_out_reg;
	reg  [5:0]  bit_cnt_reg;
	reg         sdo_oe_reg;

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// read mux; unmapped indices return zero
	function [23:0] fcr_read;
		input [4:0] idx;
		begin
			case (idx)
				`FCR_ADDR_IDENT:    fcr_read = IDENT_VALUE;
				`FCR_ADDR_ENABLE:   fcr_read = enable_reg;
				`FCR_ADDR_SETTINGS: fcr_read = settings_reg;
				`FCR_ADDR_TUNE:     fcr_read = tune_reg;
				default:            fcr_read = 24'h000000;
			endcase
		end
	endfunction

	// ----------------------------------------
	// frame engine
	// ----------------------------------------
	// frame timing, in core cycles after a pin edge:
	//  - a pin change is trusted about three cycles later
	//  - configuration moves one cycle after the trusted enable rise
	//  - the soft reset pulse rises with the commit, defaults land a cycle later
	// limitation: clock half periods under two core cycles are missed
	// limitation: an overlong frame commits the last 32 bits shifted in
	wire [23:0] frm_data = shift_in_reg[31:8];
	wire [4:0]  frm_addr = shift_in_reg[7:3];
	wire        frm_hit  = (shift_in_reg[2:0] == `FCR_CHIP_ADDR);
	wire        frm_done = sen_rise & (bit_cnt_reg == `FCR_FRAME_BITS);
	wire        take_bit = active & sck_rise;

	// rising clock edges of the frame; saturates so a long frame cannot wrap
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_reg <= 6'h00;
		end else if (clk_en_i) begin
			if (sen_fall)
				bit_cnt_reg <= 6'h00;
			else if (take_bit && bit_cnt_reg != `FCR_FRAME_BITS)
				bit_cnt_reg <= bit_cnt_reg + 6'h01;
		end
	end

	// incoming bits, most significant first
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n)
			shift_in_reg <= 32'h00000000;
		else if (clk_en_i && take_bit)
			shift_in_reg <= {shift_in_reg[30:0], sdi_bit};
	end

	// outgoing word is latched as the frame opens, so a write during the
	// frame cannot disturb the bits already on their way out
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			shift_out_reg <= 32'h00000000;
		end else if (clk_en_i) begin
			if (sen_fall)
				shift_out_reg <= {fcr_read(rptr_reg), rptr_reg, `FCR_CHIP_ADDR};
			else if (active && sck_fall && bit_cnt_reg != 6'h00)
				shift_out_reg <= {shift_out_reg[30:0], 1'b0};
		end
	end

	// ----------------------------------------
	// output drive
	// ----------------------------------------
	// a matching frame claims the data line, any other full frame frees it
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n)
			sdo_oe_reg <= 1'b0;
		else if (clk_en_i && frm_done)
			sdo_oe_reg <= frm_hit;
	end

	assign sdo_o    = shift_out_reg[31];
	assign sdo_oe_o = sdo_oe_reg;

	// ----------------------------------------
	// write strobes
	// ----------------------------------------
	// one register: full frame, our chip address, that index
	function fcr_wr_strobe;
		input [4:0] target;
		begin
			fcr_wr_strobe = frm_done & frm_hit & (frm_addr == target);
		end
	endfunction

	wire wr_ident    = fcr_wr_strobe(`FCR_ADDR_IDENT);
	wire wr_enable   = fcr_wr_strobe(`FCR_ADDR_ENABLE);
	wire wr_settings = fcr_wr_strobe(`FCR_ADDR_SETTINGS);
	wire wr_tune     = fcr_wr_strobe(`FCR_ADDR_TUNE);

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// one-cycle soft reset pulse; writing zero to the bit does nothing
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n)
			soft_reset_o <= 1'b0;
		else if (clk_en_i)
			soft_reset_o <= wr_ident & frm_data[`FCR_SOFT_RST_BIT];
	end

	// read pointer; the soft reset pulse wins over a write in the same cycle
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rptr_reg <= 5'h00;
		end else if (clk_en_i) begin
			if (soft_reset_o)
				rptr_reg <= 5'h00;
			else if (wr_ident)
				rptr_reg <= frm_data[`FCR_RPTR_MSB:0];
		end
	end

	// enable register; reserved and unused bits are masked off
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg <= `FCR_ENABLE_RST;
		end else if (clk_en_i) begin
			if (soft_reset_o)
				enable_reg <= `FCR_ENABLE_RST;
			else if (wr_enable)
				enable_reg <= frm_data & `FCR_ENABLE_MASK;
		end
	end

	// settings register; unused upper bits are masked off
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			settings_reg <= `FCR_SETTINGS_RST;
		end else if (clk_en_i) begin
			if (soft_reset_o)
				settings_reg <= `FCR_SETTINGS_RST;
			else if (wr_settings)
				settings_reg <= frm_data & `FCR_SETTINGS_MASK;
		end
	end

	// manual tune register; out-of-range codes are stored and clamped on use
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tune_reg <= `FCR_TUNE_RST;
		end else if (clk_en_i) begin
			if (soft_reset_o)
				tune_reg <= `FCR_TUNE_RST;
			else if (wr_tune)
				tune_reg <= frm_data & `FCR_TUNE_MASK;
		end
	end

	// ----------------------------------------
	// configuration decode
	// ----------------------------------------
	assign nonvolatile_ignore_o = enable_reg[`FCR_EN_NVM_IGN];
	assign use_nonvolatile_o    = ~enable_reg[`FCR_EN_NVM_IGN] & nvm_programmed_i;
	assign cal_enable_o         = enable_reg[`FCR_EN_CAL];
	assign chan_i_enable_o      = enable_reg[`FCR_EN_I];
	assign chan_q_enable_o      = enable_reg[`FCR_EN_Q];
	assign force_tune_o         = enable_reg[`FCR_EN_FORCE];
	assign doubler_enable_o     = enable_reg[`FCR_EN_DOUBLER];
	assign amp_bias_o           = settings_reg[1:0];
	assign drv_bias_o           = settings_reg[3:2];
	assign high_gain_select_o   = settings_reg[4];
	assign bypass_o             = settings_reg[5];
	assign coarse_bw_o          = settings_reg[9:6];
	// 00 = 1000 ohm, 01 = 400 ohm, 1x = 100 ohm
	assign zin_select_o = {settings_reg[`FCR_SET_ZIN_MSB], enable_reg[`FCR_EN_ZIN_LSB]};

	// ----------------------------------------
	// fine tune select
	// ----------------------------------------
	// out-of-range manual codes are clamped to the top valid step, so a
	// bad host write cannot push the filter past its characterized range
	function [3:0] fcr_clamp_tune;
		input [3:0] code;
		begin
			if (code > `FCR_TUNE_MAX)
				fcr_clamp_tune = `FCR_TUNE_MAX;
			else
				fcr_clamp_tune = code;
		end
	endfunction

	// calibration result unless the override bit is set
	assign fine_tune_o = force_tune_o ? fcr_clamp_tune(tune_reg[3:0]) : cal_result_i;

endmodule // fcr_bank
`default_nettype wire

// [verification/fcr_bank_sva.sv]
// assertion checker for the filter control bank pins
`timescale 1ns/1ps
`default_nettype none
module fcr_bank_sva (
	// clock and frame pins
	input wire logic       core_clk_i,
	input wire logic       rst_n_i,
	input wire logic       sen_n_i,
	input wire logic       sdo_oe_o,
	input wire logic       soft_reset_o,
	// configuration and status
	input wire logic       force_tune_o,
	input wire logic [3:0] fine_tune_o,
	input wire logic [3:0] cal_result_i,
	input wire logic       nonvolatile_ignore_o,
	input wire logic       nvm_programmed_i,
	input wire logic       use_nonvolatile_o,
	input wire logic [1:0] amp_bias_o,
	input wire logic [1:0] drv_bias_o,
	input wire logic       bypass_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// commits land a few cycles after the pin rises, so a long low stretch must be quiet
	sequence s_busy; !sen_n_i [*6]; endsequence
	sequence s_clear; ##2 amp_bias_o == 2'h1 && drv_bias_o == 2'h2 && !bypass_o; endsequence
	property p_pulse; soft_reset_o |=> !soft_reset_o; endproperty
	a_pulse: assert property (p_pulse) else $error("soft reset too long");
	property p_srst; soft_reset_o |-> s_clear; endproperty
	a_srst: assert property (p_srst) else $error("soft reset missed");
	property p_fine; !force_tune_o |-> fine_tune_o == cal_result_i; endproperty
	a_fine: assert property (p_fine) else $error("fine tune source");
	property p_clamp; force_tune_o |-> fine_tune_o <= 4'hB; endproperty
	a_clamp: assert property (p_clamp) else $error("fine tune range");
	property p_nvm; use_nonvolatile_o == (!nonvolatile_ignore_o && nvm_programmed_i); endproperty
	a_nvm: assert property (p_nvm) else $error("nonvolatile use");
	property p_quiet; s_busy |-> $stable({amp_bias_o, drv_bias_o, bypass_o, force_tune_o}); endproperty
	a_quiet: assert property (p_quiet) else $error("change inside frame");
	property p_oe_on; $rose(sdo_oe_o) |-> sen_n_i && $past(sen_n_i, 3); endproperty
	a_oe_on: assert property (p_oe_on) else $error("output enable early");
	property p_oe_off; $fell(sdo_oe_o) |-> sen_n_i && $past(sen_n_i, 3); endproperty
	a_oe_off: assert property (p_oe_off) else $error("output release early");
endmodule // fcr_bank_sva
`default_nettype wire

// [verification/fcr_spi_host.sv]
// host model driving serial frames into the bank
`timescale 1ns/1ps
`default_nettype none
module fcr_spi_host (
	// clock
	input  wire logic core_clk_i,
	// serial pins
	input  wire logic sdo_i,
	output var  logic sck_o,
	output var  logic sen_n_o,
	output var  logic sdi_o
);
	initial begin
		sck_o = 1'b0;
		sen_n_o = 1'b1;
		sdi_o = 1'b0;
	end
	// half periods of 8 cycles leave margin over the pin synchronisers
	task automatic frame(input logic [31:0] w, input int n, output logic [31:0] r);
		int i;
		@(posedge core_clk_i);
		sen_n_o <= 1'b0;
		sdi_o <= w[31];
		for (i = 0; i < n; i++) begin
			repeat (8) @(posedge core_clk_i);
			r = {r[30:0], sdo_i};
			sck_o <= 1'b1;
			repeat (8) @(posedge core_clk_i);
			sck_o <= 1'b0;
			sdi_o <= (i < 31) ? w[30 - i] : ~w[0];
		end
		repeat (8) @(posedge core_clk_i);
		sen_n_o <= 1'b1;
		// released data line must not keep the last bit
		sdi_o <= ~sdi_o;
		repeat (12) @(posedge core_clk_i);
	endtask
endmodule // fcr_spi_host
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the filter control bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        core_clk_i = 1'b0;
	logic        rst_n_i    = 1'b0;
	logic        nvm_i      = 1'b1;
	logic [3:0]  cal_i      = 4'h6;
	logic        sck, sen_n, sdi, sdo, oe, nvi, cal, ei, eq, frc, dbl, hg, byp, srst, use_nv;
	logic [1:0]  ab, db, zin;
	logic [3:0]  cbw, ft;
	logic [31:0] rd;
	int          fail_count = 0;
	int          n_compared = 0;
	wire  [5:0]  ev = {dbl, frc, eq, ei, cal, nvi};
	wire  [10:0] sv = {zin[1], cbw, byp, hg, db, ab};
	fcr_bank dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .sck_i(sck),
		.sen_n_i(sen_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(oe), .nonvolatile_ignore_o(nvi),
		.cal_enable_o(cal), .chan_i_enable_o(ei), .chan_q_enable_o(eq), .force_tune_o(frc),
		.doubler_enable_o(dbl), .amp_bias_o(ab), .drv_bias_o(db), .high_gain_select_o(hg),
		.bypass_o(byp), .coarse_bw_o(cbw), .zin_select_o(zin), .fine_tune_o(ft),
		.use_nonvolatile_o(use_nv), .soft_reset_o(srst), .nvm_programmed_i(nvm_i),
		.cal_result_i(cal_i));
	fcr_spi_host host (.core_clk_i(core_clk_i), .sdo_i(sdo), .sck_o(sck), .sen_n_o(sen_n),
		.sdi_o(sdi));
	initial forever #50 core_clk_i = ~core_clk_i;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task wr(input logic [4:0] a, input logic [23:0] d, input logic [2:0] c);
		host.frame({d, a, c}, 32, rd);
	endtask
	// pointer frame first, the second frame rewrites the same pointer
	task rdb(input logic [4:0] a);
		wr(5'h00, {19'h0, a}, 3'h5);
		host.frame({19'h0, a, 5'h00, 3'h5}, 32, rd);
	endtask
	task t_reset;
		chk(32'(ev), 32'h0C);
		chk(32'(sv), 32'h009);
		chk(32'({zin, ft, use_nv}), 32'h0D);
		@(posedge core_clk_i);
		nvm_i <= 1'b0;
		@(posedge core_clk_i);
		chk(32'(use_nv), 32'h0);
		nvm_i <= 1'b1;
		@(posedge core_clk_i);
		chk(32'(use_nv), 32'h1);
	endtask
	// upper pointer bits are don't care and must not reach the ident word
	task t_ident;
		wr(5'h00, 24'hFFFFC0, 3'h5);
		host.frame(32'h5, 32, rd);
		chk(rd, {24'h123456, 5'h00, 3'h5});
	endtask
	task t_rw;
		wr(5'h01, 24'hFFFFFF, 3'h5);
		chk(32'({ev, zin[0], use_nv}), 32'hFE);
		rdb(5'h01);
		chk(rd, {24'h00023F, 5'h01, 3'h5});
		wr(5'h02, 24'hFFFFFF, 3'h5);
		chk(32'({sv, oe}), 32'hFFF);
		rdb(5'h02);
		chk(rd, {24'h0007FF, 5'h02, 3'h5});
		wr(5'h03, 24'hFFFFFF, 3'h5);
		chk(32'(ft), 32'hB);
		wr(5'h01, 24'h000000, 3'h5);
		chk(32'({ft, use_nv}), 32'hD);
	endtask
	task t_refuse;
		wr(5'h02, 24'h000000, 3'h4);
		chk(32'({sv, oe}), 32'hFFE);
		host.frame({24'h0, 5'h02, 3'h5}, 31, rd);
		chk(32'(sv), 32'h7FF);
	endtask
	task t_soft;
		wr(5'h00, 24'h000020, 3'h5);
		chk(32'({ev, sv}), 32'h6009);
		wr(5'h00, 24'h000000, 3'h5);
	endtask
	initial begin
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		t_reset;
		t_ident;
		t_rw;
		t_refuse;
		t_soft;
		give_verdict;
	end
	// hang guard
	initial begin
		#5000000;
		fail_count++;
		give_verdict;
	end
endmodule // testbench
bind fcr_bank fcr_bank_sva u_sva (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
	.sen_n_i(sen_n_i), .sdo_oe_o(sdo_oe_o), .soft_reset_o(soft_reset_o),
	.force_tune_o(force_tune_o), .fine_tune_o(fine_tune_o), .cal_result_i(cal_result_i),
	.nonvolatile_ignore_o(nonvolatile_ignore_o), .nvm_programmed_i(nvm_programmed_i),
	.use_nonvolatile_o(use_nonvolatile_o), .amp_bias_o(amp_bias_o),
	.drv_bias_o(drv_bias_o), .bypass_o(bypass_o));
`default_nettype wire
